// ===== glyph_icon_map.sv
// Function
// - Code bits 2..0 form glyph address 5..3 on full strap; bit 5 held zero on small strap
// - Glyph address bits 2..0 pick line
// - Eighth line ORed with cursor pattern
// - Stored one on eighth line always lit
// - Data bits 4..0 drive dots, 4 left
// - Codes with high nibble zero select glyphs
// - One lights dot, zero leaves it dark
// - Straps choose glyph store size
// - Sixteen icon bytes, only D4..D0 matter
// - Forward scan, optional pairing on 80 higher
// - Reverse scan unpaired flips the eighty icon segments 79..0, segments 99..80 dark
// - Reverse scan paired mirrors first twenty segments
`timescale 1ns/10ps
module glyph_icon_map (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic      [7:0]   reg_rdata,
	input  wire logic [1:0]   glyph_ram_size_straps,
	input  wire logic         disp_req,
	input  wire logic [7:0]   char_code,
	input  wire logic [2:0]   line_index,
	input  wire logic         cursor_on,
	output logic      [4:0]   dot_row,
	output logic              dot_valid,
	output logic              glyph_hit,
	output logic      [99:0]  segment_out
);
	localparam int NSEG = glyph_icon_pkg::SEG_COUNT;
	localparam int NICO = glyph_icon_pkg::ICON_SEGS;
	localparam int NPAI = glyph_icon_pkg::PAIR_SEGS;

	typedef enum logic [1:0] {
		STRAP_WAIT,
		STRAP_HELD
	} strap_state_t;

	typedef struct packed {
		logic [glyph_icon_pkg::GLYPH_BYTES-1:0][7:0] glyph;
		logic [glyph_icon_pkg::ICON_BYTES-1:0][7:0]  icon;
		logic                                        scan_dir;
		logic                                        pairing;
		logic [1:0]                                  straps;
		strap_state_t                                strap_st;
		logic [7:0]                                  rdata;
		logic [4:0]                                  dots;
		logic                                        dvalid;
		logic                                        hit;
		logic [NSEG-1:0]                             seg;
	} state_t;

	state_t            state_reg;
	state_t            state_next;
	logic   [NSEG-1:0] seg_map;
	logic              full;
	logic              glyph_sel;
	logic              icon_sel;
	logic              glyph_ok;

	glyph_if gi ();

	glyph_row_decode u_decode (
		.gi (gi.decode)
	);

	assign full        = (state_reg.straps == glyph_icon_pkg::STRAP_FULL);
	assign gi.code     = char_code;
	assign gi.line     = line_index;
	assign gi.cursor   = cursor_on;
	assign gi.full     = full;
	assign gi.row_data = state_reg.glyph[gi.addr];

	assign glyph_sel = (reg_addr <= glyph_icon_pkg::GLYPH_LAST);
	assign icon_sel  = (reg_addr >= glyph_icon_pkg::ICON_BASE) &&
	                   (reg_addr <= glyph_icon_pkg::ICON_LAST);
	// Upper half of the store does not exist with the small strap
	assign glyph_ok  = glyph_sel && (full || !reg_addr[5]);

	// Each segment picks its icon bit from fixed positions per mode
	for (genvar s = 0; s < NSEG; s++) begin : g_seg
		localparam int FA = s % NICO;
		localparam int RB = (s < NICO) ? (NICO - 1 - s) : 0;
		localparam int RC = (s >= NPAI) ? (NSEG - 1 - s) : (NPAI - 1 - s);
		logic bit_a;
		logic bit_b;
		logic bit_c;
		// Only D4..D0 are referenced; D7..D5 never reach a segment
		assign bit_a = state_reg.icon[FA / 5][4 - (FA % 5)];
		assign bit_b = state_reg.icon[RB / 5][4 - (RB % 5)];
		assign bit_c = state_reg.icon[RC / 5][4 - (RC % 5)];
		always_comb begin
			if (state_reg.scan_dir) begin
				seg_map[s] = (s < NICO || !state_reg.pairing) ? bit_a : 1'b0;
			end else if (state_reg.pairing) begin
				seg_map[s] = (s < NICO) ? bit_b : 1'b0;
			end else begin
				seg_map[s] = bit_c;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.rdata = 8'h00;
		// Straps are fixed wiring; take them once after reset release
		case (state_reg.strap_st)
			STRAP_WAIT: begin
				state_next.straps   = glyph_ram_size_straps;
				state_next.strap_st = STRAP_HELD;
			end
			STRAP_HELD: begin
				state_next.strap_st = STRAP_HELD;
			end
			default: begin
				state_next.strap_st = STRAP_WAIT;
			end
		endcase
		if (reg_wr) begin
			if (glyph_ok) begin
				state_next.glyph[reg_addr[5:0]] = reg_wdata;
			end else if (icon_sel) begin
				state_next.icon[reg_addr[3:0]] = reg_wdata;
			end else if (reg_addr == glyph_icon_pkg::CTRL_ADDR) begin
				state_next.scan_dir = reg_wdata[glyph_icon_pkg::CTRL_SCAN_BIT];
				state_next.pairing  = reg_wdata[glyph_icon_pkg::CTRL_PAIR_BIT];
			end
		end
		if (reg_rd) begin
			if (glyph_ok) begin
				state_next.rdata = state_reg.glyph[reg_addr[5:0]];
			end else if (icon_sel) begin
				state_next.rdata = state_reg.icon[reg_addr[3:0]];
			end else if (reg_addr == glyph_icon_pkg::CTRL_ADDR) begin
				state_next.rdata[glyph_icon_pkg::CTRL_SCAN_BIT] = state_reg.scan_dir;
				state_next.rdata[glyph_icon_pkg::CTRL_PAIR_BIT] = state_reg.pairing;
			end else if (reg_addr == glyph_icon_pkg::STATUS_ADDR) begin
				state_next.rdata[glyph_icon_pkg::STAT_STRAP_LSB +: 2] = state_reg.straps;
				state_next.rdata[glyph_icon_pkg::STAT_FULL_BIT]       = full;
			end
		end
		// Glyph row stage: one row per request, result next cycle
		state_next.dvalid = disp_req;
		if (disp_req) begin
			state_next.dots = gi.dots;
			state_next.hit  = gi.user_sel;
		end
		// Icon map refreshed every enabled cycle, no write trigger
		state_next.seg = seg_map;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg          <= '0;
			state_reg.scan_dir <= glyph_icon_pkg::CTRL_RESET[glyph_icon_pkg::CTRL_SCAN_BIT];
			state_reg.pairing  <= glyph_icon_pkg::CTRL_RESET[glyph_icon_pkg::CTRL_PAIR_BIT];
			state_reg.strap_st <= STRAP_WAIT;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata   = state_reg.rdata;
	assign dot_row     = state_reg.dots;
	assign dot_valid   = state_reg.dvalid;
	assign glyph_hit   = state_reg.hit;
	assign segment_out = state_reg.seg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_addr_high;
		full |-> gi.addr[5:3] == char_code[2:0];
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("glyph address high bits wrong");

	property p_addr_line;
		gi.addr[2:0] == line_index;
	endproperty
	a_addr_line: assert property (p_addr_line) else $error("glyph line select wrong");

	property p_cursor_or;
		clk_en && disp_req && char_code[7:4] == 4'h0 && line_index == 3'h7 && cursor_on
		|=> dot_row == 5'h1F;
	endproperty
	a_cursor_or: assert property (p_cursor_or) else $error("cursor line not fully lit");

	property p_line8_lit;
		clk_en && disp_req && char_code[7:4] == 4'h0 && line_index == 3'h7
		|=> (dot_row & $past(gi.row_data[4:0])) == $past(gi.row_data[4:0]);
	endproperty
	a_line8_lit: assert property (p_line8_lit) else $error("stored dot lost on cursor line");

	property p_dot_order;
		clk_en && disp_req && char_code[7:4] == 4'h0 && line_index != 3'h7
		|=> dot_row[4] == $past(gi.row_data[4]) && dot_row[0] == $past(gi.row_data[0]);
	endproperty
	a_dot_order: assert property (p_dot_order) else $error("dot column order wrong");

	property p_user_sel;
		clk_en && disp_req |=> glyph_hit == ($past(char_code[7:4]) == 4'h0);
	endproperty
	a_user_sel: assert property (p_user_sel) else $error("user glyph select wrong");

	property p_bit3_ignored;
		clk_en && disp_req && full && char_code[7:3] == 5'h01 && !cursor_on
		|=> dot_row == $past(state_reg.glyph[{char_code[2:0], line_index}][4:0]);
	endproperty
	a_bit3_ignored: assert property (p_bit3_ignored) else $error("code bit 3 affects address");

	property p_dark_dots;
		clk_en && disp_req && line_index != 3'h7 && gi.row_data[4:0] == 5'h00
		|=> dot_row == 5'h00;
	endproperty
	a_dark_dots: assert property (p_dark_dots) else $error("unselected dot lit");

	property p_small_store;
		clk_en && !full && reg_wr && reg_addr[7:5] == 3'h1 |=> $stable(state_reg.glyph);
	endproperty
	a_small_store: assert property (p_small_store) else $error("write beyond small store");

	property p_icon_rw;
		clk_en && reg_wr && reg_addr == 8'h4F ##1 !reg_wr
		##1 clk_en && reg_rd && reg_addr == 8'h4F
		|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_icon_rw: assert property (p_icon_rw) else $error("icon byte readback wrong");

	property p_fwd_map;
		clk_en && state_reg.scan_dir
		|=> segment_out[0] == $past(state_reg.icon[0][4]) &&
		    segment_out[79] == $past(state_reg.icon[15][0]) &&
		    segment_out[80] == ($past(state_reg.pairing) ? 1'b0 : $past(state_reg.icon[0][4]));
	endproperty
	a_fwd_map: assert property (p_fwd_map) else $error("forward icon map wrong");

	property p_rev_unpaired;
		clk_en && !state_reg.scan_dir && state_reg.pairing
		|=> segment_out[79] == $past(state_reg.icon[0][4]) &&
		    segment_out[0] == $past(state_reg.icon[15][0]) && segment_out[99:80] == 20'h00000;
	endproperty
	a_rev_unpaired: assert property (p_rev_unpaired) else $error("reverse icon map wrong");

	property p_rev_paired;
		clk_en && !state_reg.scan_dir && !state_reg.pairing
		|=> segment_out[99] == $past(state_reg.icon[0][4]) &&
		    segment_out[19] == $past(state_reg.icon[0][4]) &&
		    segment_out[79] == $past(state_reg.icon[4][4]);
	endproperty
	a_rev_paired: assert property (p_rev_paired) else $error("paired reverse map wrong");

	property p_refresh;
		clk_en && reg_wr && reg_addr == 8'h40 && state_reg.scan_dir ##1 clk_en
		|=> segment_out[0] == $past(reg_wdata[4], 2);
	endproperty
	a_refresh: assert property (p_refresh) else $error("icon change not shown");

	// Low enable must hold every flop, read data included
	property p_freeze;
		!clk_en |=> $stable(state_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_valid_pulse;
		clk_en && !disp_req |=> !dot_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("dot valid without request");

	property p_dots_hold;
		clk_en && !disp_req |=> $stable(dot_row) && $stable(glyph_hit);
	endproperty
	a_dots_hold: assert property (p_dots_hold) else $error("dot row changed without request");

	property p_rdata_idle;
		clk_en && !reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	property p_glyph_rw;
		clk_en && reg_wr && full && reg_addr <= 8'h3F ##1 !reg_wr
		##1 clk_en && reg_rd && reg_addr == $past(reg_addr, 2)
		|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_glyph_rw: assert property (p_glyph_rw) else $error("glyph byte readback wrong");

	property p_unmapped_rd;
		clk_en && reg_rd && reg_addr > 8'h51 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

	property p_small_read;
		clk_en && reg_rd && !full && reg_addr[7:5] == 3'h1 |=> reg_rdata == 8'h00;
	endproperty
	a_small_read: assert property (p_small_read) else $error("read beyond small store");

	// Straps are fixed wiring, so the pins still show the latched code
	property p_status_rd;
		clk_en && reg_rd && reg_addr == 8'h51 && state_reg.strap_st == STRAP_HELD
		|=> reg_rdata[1:0] == $past(glyph_ram_size_straps) && reg_rdata[7:3] == 5'h00 &&
		    reg_rdata[2] == ($past(glyph_ram_size_straps) == 2'h0);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read wrong");

	property p_ctrl_rw;
		clk_en && reg_wr && reg_addr == 8'h50
		|=> state_reg.scan_dir == $past(reg_wdata[0]) && state_reg.pairing == $past(reg_wdata[1]);
	endproperty
	a_ctrl_rw: assert property (p_ctrl_rw) else $error("control write not taken");

	property p_fwd_mid;
		clk_en && state_reg.scan_dir
		|=> segment_out[24] == $past(state_reg.icon[4][0]) &&
		    segment_out[5] == $past(state_reg.icon[1][4]);
	endproperty
	a_fwd_mid: assert property (p_fwd_mid) else $error("forward icon map middle wrong");

	property p_fwd_unpaired_top;
		clk_en && state_reg.scan_dir && state_reg.pairing |=> segment_out[99:80] == 20'h00000;
	endproperty
	a_fwd_unpaired_top: assert property (p_fwd_unpaired_top) else $error("top segments lit");

	property p_rev_paired_low;
		clk_en && !state_reg.scan_dir && !state_reg.pairing
		|=> segment_out[0] == $past(state_reg.icon[3][0]) &&
		    segment_out[80] == $past(state_reg.icon[3][0]) &&
		    segment_out[20] == $past(state_reg.icon[15][0]);
	endproperty
	a_rev_paired_low: assert property (p_rev_paired_low) else $error("paired low map wrong");

	property p_hit_dark;
		clk_en && disp_req && char_code[7:4] != 4'h0 |=> dot_row == 5'h00;
	endproperty
	a_hit_dark: assert property (p_hit_dark) else $error("non-user code lit dots");

	property p_cursor_off;
		clk_en && disp_req && char_code[7:4] == 4'h0 && line_index == 3'h7 && !cursor_on
		|=> dot_row == $past(gi.row_data[4:0]);
	endproperty
	a_cursor_off: assert property (p_cursor_off) else $error("cursor line without cursor");
endmodule

// ===== glyph_icon_map_bench.sv
`timescale 1ns/10ps
module glyph_icon_map_bench;
	logic         ref_clk;
	logic         rst_n;
	logic         clk_en;
	logic [7:0]   reg_addr;
	logic [7:0]   reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic [7:0]   reg_rdata;
	logic [1:0]   glyph_ram_size_straps;
	logic         disp_req;
	logic [7:0]   char_code;
	logic [2:0]   line_index;
	logic         cursor_on;
	logic [4:0]   dot_row;
	logic         dot_valid;
	logic         glyph_hit;
	logic [99:0]  segment_out;
	logic [7:0]   icon [16];
	logic [7:0]   glyph [64];
	logic [4:0]   exp_dots;
	int           n_fail;
	int           checked;
	int           cycles;

	glyph_icon_map uut (
		.ref_clk               (ref_clk),
		.rst_n                 (rst_n),
		.clk_en                (clk_en),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rdata             (reg_rdata),
		.glyph_ram_size_straps (glyph_ram_size_straps),
		.disp_req              (disp_req),
		.char_code             (char_code),
		.line_index            (line_index),
		.cursor_on             (cursor_on),
		.dot_row               (dot_row),
		.dot_valid             (dot_valid),
		.glyph_hit             (glyph_hit),
		.segment_out           (segment_out)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Generous ceiling; the sequence needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [99:0] exp, input logic [99:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 chk("reg_rdata", 100'(exp), 100'(reg_rdata));
	endtask

	task automatic req(input logic [7:0] c, input logic [2:0] l, input logic cur,
			input logic [4:0] exp, input logic hit);
		@(posedge ref_clk);
		disp_req   <= 1'b1;
		char_code  <= c;
		line_index <= l;
		cursor_on  <= cur;
		@(posedge ref_clk);
		disp_req   <= 1'b0;
		#1;
		chk("dot_valid", 100'(1'b1), 100'(dot_valid));
		chk("dot_row", 100'(exp), 100'(dot_row));
		chk("glyph_hit", 100'(hit), 100'(glyph_hit));
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask

	// Bit D4 is the first segment of each group of five
	function automatic logic [99:0] seg_exp(input logic [1:0] c);
		logic [99:0] s;
		logic        b;
		int          p;
		s = '0;
		for (int n = 0; n < 16; n++) begin
			for (int k = 0; k < 5; k++) begin
				p = 5 * n + k;
				b = icon[n][4-k];
				if (c[0]) begin
					s[p] = b;
					if (!c[1] && n < 4) s[p+80] = b;
				end else if (c[1]) begin
					s[79-p] = b;
				end else begin
					s[99-p] = b;
					if (n < 4) s[19-p] = b;
				end
			end
		end
		return s;
	endfunction

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		glyph_ram_size_straps = 2'h0;
		disp_req = 1'b0;
		char_code = 8'h00;
		line_index = 3'h0;
		cursor_on = 1'b0;
		do_reset();
		rd(glyph_icon_pkg::CTRL_ADDR, glyph_icon_pkg::CTRL_RESET);
		rd(glyph_icon_pkg::STATUS_ADDR, 8'h04);
		chk("segment_out", '0, segment_out);
		// Cursor rows of odd glyphs keep zero data so only the cursor lights them
		for (int i = 0; i < 64; i++) begin
			glyph[i] = (i % 16 == 15) ? 8'hA0 : {3'h5, 5'(i * 3 + 1)};
			wr(8'(i), glyph[i]);
		end
		rd(glyph_icon_pkg::GLYPH_LAST, glyph[63]);
		for (int c = 0; c < 16; c++) begin
			for (int l = 0; l < 8; l++) begin
				exp_dots = glyph[(c % 8) * 8 + l][4:0] | ((l == 7 && c % 2 == 1) ? 5'h1F : 5'h00);
				req(8'(c), 3'(l), 1'(c % 2), exp_dots, 1'b1);
			end
		end
		@(posedge ref_clk);
		#1 chk("dot_valid low", '0, 100'(dot_valid));
		req(8'h10, 3'h7, 1'b1, 5'h00, 1'b0);
		req(8'h27, 3'h2, 1'b0, 5'h00, 1'b0);
		req(8'hF8, 3'h7, 1'b1, 5'h00, 1'b0);
		for (int n = 0; n < 16; n++) begin
			icon[n] = 8'hE0 | 8'((n * 7 + 3) % 32);
			wr(glyph_icon_pkg::ICON_BASE + 8'(n), icon[n]);
		end
		rd(glyph_icon_pkg::ICON_LAST, icon[15]);
		@(posedge ref_clk);
		#1 chk("reg_rdata idle", '0, 100'(reg_rdata));
		for (int m = 0; m < 4; m++) begin
			wr(glyph_icon_pkg::CTRL_ADDR, 8'(m));
			@(posedge ref_clk);
			#1 chk("segment_out", seg_exp(2'(m)), segment_out);
		end
		icon[0] = 8'h1F;
		wr(glyph_icon_pkg::ICON_BASE, icon[0]);
		@(posedge ref_clk);
		#1 chk("segment_out update", seg_exp(2'h3), segment_out);
		// Write while disabled must be dropped and outputs frozen
		clk_en <= 1'b0;
		wr(glyph_icon_pkg::ICON_BASE, 8'h00);
		@(posedge ref_clk);
		#1 chk("segment_out frozen", seg_exp(2'h3), segment_out);
		clk_en <= 1'b1;
		rd(glyph_icon_pkg::ICON_BASE, icon[0]);
		wr(8'h52, 8'hFF);
		rd(8'h52, 8'h00);
		wr(glyph_icon_pkg::STATUS_ADDR, 8'hFF);
		rd(glyph_icon_pkg::STATUS_ADDR, 8'h04);
		glyph_ram_size_straps <= 2'h1;
		do_reset();
		rd(glyph_icon_pkg::STATUS_ADDR, 8'h01);
		wr(8'h20, 8'h1F);
		rd(8'h20, 8'h00);
		wr(8'h03, 8'h15);
		req(8'h04, 3'h3, 1'b0, 5'h15, 1'b1);
		complete_run();
	end
endmodule

// ===== glyph_icon_pkg.sv
package glyph_icon_pkg;
	// Register port byte addresses
	localparam logic [7:0] GLYPH_BASE   = 8'h00;
	localparam logic [7:0] GLYPH_LAST   = 8'h3F;
	localparam logic [7:0] ICON_BASE    = 8'h40;
	localparam logic [7:0] ICON_LAST    = 8'h4F;
	localparam logic [7:0] CTRL_ADDR    = 8'h50;
	localparam logic [7:0] STATUS_ADDR  = 8'h51;
	// Control register fields and reset value
	localparam int         CTRL_SCAN_BIT = 0;
	localparam int         CTRL_PAIR_BIT = 1;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	// Status register fields
	localparam int         STAT_STRAP_LSB = 0;
	localparam int         STAT_FULL_BIT  = 2;
	// Strap code that gives the full eight-glyph store
	localparam logic [1:0] STRAP_FULL    = 2'h0;
	// Glyph store geometry
	localparam int         GLYPH_BYTES   = 64;
	localparam int         DOTS          = 5;
	localparam logic [2:0] CURSOR_LINE   = 3'h7;
	localparam logic [4:0] CURSOR_DOTS   = 5'h1F;
	// Icon store geometry
	localparam int         ICON_BYTES    = 16;
	localparam int         ICON_BITS     = 5;
	localparam int         ICON_SEGS     = 80;
	localparam int         PAIR_SEGS     = 20;
	localparam int         SEG_COUNT     = 100;
endpackage

// ===== glyph_if.sv
`timescale 1ns/10ps
interface glyph_if;
	logic [7:0] code;
	logic [2:0] line;
	logic       cursor;
	logic       full;
	logic [7:0] row_data;
	logic [5:0] addr;
	logic       user_sel;
	logic [4:0] dots;

	modport decode (
		input  code,
		input  line,
		input  cursor,
		input  full,
		input  row_data,
		output addr,
		output user_sel,
		output dots
	);
	modport core (
		output code,
		output line,
		output cursor,
		output full,
		output row_data,
		input  addr,
		input  user_sel,
		input  dots
	);
endinterface

// ===== glyph_row_decode.sv
`timescale 1ns/10ps
module glyph_row_decode (
	glyph_if.decode gi
);
	logic cursor_row;

	// Reduced store aliases the upper half onto the lower
	assign gi.addr = {gi.full & gi.code[2], gi.code[1:0], gi.line};

	// Code bit 3 deliberately left out of the decode
	assign gi.user_sel = (gi.code[7:4] == 4'h0);

	assign cursor_row = (gi.line == glyph_icon_pkg::CURSOR_LINE) && gi.cursor;

	// Stored ones stay lit; cursor only adds dots
	always_comb begin
		gi.dots = gi.row_data[4:0];
		if (cursor_row) begin
			gi.dots = gi.row_data[4:0] | glyph_icon_pkg::CURSOR_DOTS;
		end
		if (!gi.user_sel) begin
			gi.dots = 5'h00;
		end
	end
endmodule
